/* File: inc/rxbc_pkg.sv */
// Constants, register map and types of the receive bit-check and buffer controller
package rxbc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL1   = 8'h00;
  localparam logic [7:0] ADDR_CTRL3   = 8'h04;
  localparam logic [7:0] ADDR_CTRL4   = 8'h08;
  localparam logic [7:0] ADDR_CTRL5   = 8'h0c;
  localparam logic [7:0] ADDR_CTRL6   = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_DATA    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h1c;

  // Field positions
  localparam int CTRL1_OPM_LSB   = 0;
  localparam int CTRL1_TMODE_BIT = 2;
  localparam int CTRL1_PMODE_BIT = 3;
  localparam int CTRL1_THR_LSB   = 4;
  localparam int CTRL3_SUPPLY_BIT = 0;
  localparam int CTRL3_CLOCK_BIT  = 1;
  localparam int CTRL4_SLEEP_LSB = 0;
  localparam int CTRL4_XSLP_BIT  = 5;
  localparam int CTRL5_LMIN_LSB  = 0;
  localparam int CTRL5_NBIT_LSB  = 6;
  localparam int CTRL6_LMAX_LSB  = 0;
  localparam int STAT_CNT_LSB    = 0;
  localparam int STAT_STATE_LSB  = 8;
  localparam int STAT_IRQ_BIT    = 12;

  // Values after reset
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [1:0] CTRL3_RST = 2'h0;
  localparam logic [5:0] CTRL4_RST = 6'h00;
  localparam logic [7:0] CTRL5_RST = 8'h4c;
  localparam logic [5:0] CTRL6_RST = 6'h22;

  // Operating mode codes
  localparam logic [1:0] OPM_RX_POLL = 2'h2;
  localparam logic [1:0] OPM_RX      = 2'h3;

  // Fill threshold per fill_irq_threshold code
  localparam logic [4:0] FILL_THR_0 = 5'h01;
  localparam logic [4:0] FILL_THR_1 = 5'h04;
  localparam logic [4:0] FILL_THR_2 = 5'h08;
  localparam logic [4:0] FILL_THR_3 = 5'h0c;

  // Bit-check sizing
  localparam int BITS_PER_STEP  = 3;
  localparam int CHECKS_PER_BIT = 2;
  localparam int BUF_DEPTH      = 16;

  // Timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int CHECK_CLK_PERIOD_NS = 1000;
  localparam int CHECK_DIV_CYCLES    = (CHECK_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SIG_SETTLE_NS       = 64000;
  localparam int SIG_SETTLE_TICKS    = SIG_SETTLE_NS / CHECK_CLK_PERIOD_NS;
  localparam int SLEEP_UNIT_LOG2     = 10;
  localparam int SLEEP_EXT_LOG2      = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {ST_OFF, ST_SLEEP, ST_PLL, ST_SETTLE, ST_CHECK, ST_RECV} rxbc_state_t;

endpackage

/* File: logic/rxbc_sync.sv */
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ns
module rxbc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* File: logic/rxbc_top.sv */
// Receive start-up sequencer, bit-check engine and Manchester byte buffer with AXI4-Lite registers
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module rxbc_top #(
  parameter int unsigned CHECK_DIV    = rxbc_pkg::CHECK_DIV_CYCLES,
  parameter int unsigned SETTLE_TICKS = rxbc_pkg::SIG_SETTLE_TICKS
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog front end
  input  wire logic        demod_in,
  input  wire logic        pll_locked,
  output logic             synth_enable,
  output logic             sig_proc_enable,
  output logic             rx_active,
  // Host side
  input  wire logic        chip_select_n,
  output logic             serial_out_rx_stream,
  output logic             serial_out_oe,
  output logic             host_supply_enable,
  output logic             host_clock_enable,
  output logic             irq
);

  logic [2:0] sync_q;
  logic       demod_s;
  logic       pll_s;
  logic       cs_n_s;

  rxbc_sync #(.WIDTH(3)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({demod_in, pll_locked, chip_select_n}),
    .sync_out (sync_q)
  );
  assign demod_s = sync_q[2];
  assign pll_s   = sync_q[1];
  assign cs_n_s  = sync_q[0];

  // Bus state
  logic [7:0]  awaddr_q, awaddr_d;
  logic        aw_have_q, aw_have_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        w_have_q, w_have_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        wr_go;
  logic        ar_fire;
  logic        pop;

  // Core state
  rxbc_pkg::rxbc_state_t state_q, state_d;
  logic [7:0]  ctrl1_q, ctrl1_d;
  logic [1:0]  ctrl3_q, ctrl3_d;
  logic [5:0]  ctrl4_q, ctrl4_d;
  logic [7:0]  ctrl5_q, ctrl5_d;
  logic [5:0]  ctrl6_q, ctrl6_d;
  logic [15:0] div_q, div_d;
  logic [7:0]  timer_q, timer_d;
  logic [4:0]  pass_q, pass_d;
  logic [17:0] sleep_q, sleep_d;
  logic [15:0] settle_q, settle_d;
  logic        armed_q, armed_d;
  logic        started_q, started_d;
  logic        centre_q, centre_d;
  logic [7:0]  shreg_q, shreg_d;
  logic [2:0]  bitcnt_q, bitcnt_d;
  logic [3:0]  wr_q, wr_d;
  logic [3:0]  rd_q, rd_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        irq_q, irq_d;
  logic        demod_prev_q;
  logic        so_q, so_d;
  logic        oe_q, oe_d;
  logic [7:0]  mem [rxbc_pkg::BUF_DEPTH];
  logic        buf_we;
  logic [7:0]  buf_wdata;

  // Derived controls
  logic        tick;
  logic        edge_seen;
  logic        tmode;
  logic        pmode;
  logic [1:0]  opm;
  logic [7:0]  lmin;
  logic [7:0]  lmax;
  logic [7:0]  diff;
  logic [7:0]  lmin2;
  logic [7:0]  lmax2;
  logic [4:0]  need;
  logic [4:0]  fill_thr;

  assign tick      = (div_q == 16'(CHECK_DIV - 1));
  assign edge_seen = demod_s ^ demod_prev_q;
  assign opm       = ctrl1_q[rxbc_pkg::CTRL1_OPM_LSB +: 2];
  assign tmode     = ctrl1_q[rxbc_pkg::CTRL1_TMODE_BIT];
  assign pmode     = ctrl1_q[rxbc_pkg::CTRL1_PMODE_BIT];
  assign lmin      = {2'h0, ctrl5_q[rxbc_pkg::CTRL5_LMIN_LSB +: 6]};
  assign lmax      = {2'h0, ctrl6_q[rxbc_pkg::CTRL6_LMAX_LSB +: 6]};
  assign diff      = lmax - lmin;
  // Odd difference: floor on the lower bound, ceiling on the upper, both round the result up
  assign lmin2     = lmin + lmax - {1'b0, diff[7:1]};
  assign lmax2     = lmin + lmax + {1'b0, diff[7:1]} + {7'h0, diff[0]};
  assign need      = 5'(ctrl5_q[rxbc_pkg::CTRL5_NBIT_LSB +: 2] * rxbc_pkg::BITS_PER_STEP
                     * rxbc_pkg::CHECKS_PER_BIT);

  always_comb
  begin
    case (ctrl1_q[rxbc_pkg::CTRL1_THR_LSB +: 2])
      2'h0:    fill_thr = rxbc_pkg::FILL_THR_0;
      2'h1:    fill_thr = rxbc_pkg::FILL_THR_1;
      2'h2:    fill_thr = rxbc_pkg::FILL_THR_2;
      default: fill_thr = rxbc_pkg::FILL_THR_3;
    endcase
  end

  // AXI4-Lite slave
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go         = aw_have_q && w_have_q && !bvalid_q;
  assign ar_fire       = s_axi_arvalid && !rvalid_q;
  assign pop           = ar_fire && (s_axi_araddr == rxbc_pkg::ADDR_DATA);

  always_comb
  begin
    awaddr_d  = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    w_have_d  = w_have_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_d  = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_d  = s_axi_wdata[7:0];
      wstrb0_d = s_axi_wstrb[0];
      w_have_d = 1'b1;
    end
    if (wr_go)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      if (awaddr_q == rxbc_pkg::ADDR_CTRL1 || awaddr_q == rxbc_pkg::ADDR_CTRL3
          || awaddr_q == rxbc_pkg::ADDR_CTRL4 || awaddr_q == rxbc_pkg::ADDR_CTRL5
          || awaddr_q == rxbc_pkg::ADDR_CTRL6 || awaddr_q == rxbc_pkg::ADDR_STATUS
          || awaddr_q == rxbc_pkg::ADDR_DATA || awaddr_q == rxbc_pkg::ADDR_IRQ_CLR)
        bresp_d = rxbc_pkg::RESP_OKAY;
      else
        bresp_d = rxbc_pkg::RESP_DECERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (ar_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d  = rxbc_pkg::RESP_OKAY;
      rdata_d  = 32'h0;
      if (s_axi_araddr == rxbc_pkg::ADDR_CTRL1)
        rdata_d[7:0] = ctrl1_q;
      else if (s_axi_araddr == rxbc_pkg::ADDR_CTRL3)
        rdata_d[1:0] = ctrl3_q;
      else if (s_axi_araddr == rxbc_pkg::ADDR_CTRL4)
        rdata_d[5:0] = ctrl4_q;
      else if (s_axi_araddr == rxbc_pkg::ADDR_CTRL5)
        rdata_d[7:0] = ctrl5_q;
      else if (s_axi_araddr == rxbc_pkg::ADDR_CTRL6)
        rdata_d[5:0] = ctrl6_q;
      else if (s_axi_araddr == rxbc_pkg::ADDR_STATUS)
      begin
        rdata_d[rxbc_pkg::STAT_CNT_LSB +: 5]   = cnt_q;
        rdata_d[rxbc_pkg::STAT_STATE_LSB +: 3] = state_q;
        rdata_d[rxbc_pkg::STAT_IRQ_BIT]        = irq_q;
      end
      else if (s_axi_araddr == rxbc_pkg::ADDR_DATA)
      begin
        if (cnt_q != 5'h0)
          rdata_d[7:0] = mem[rd_q];
      end
      else if (s_axi_araddr == rxbc_pkg::ADDR_IRQ_CLR)
        rdata_d = 32'h0;
      else
        rresp_d = rxbc_pkg::RESP_DECERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_q  <= 8'h0;
      aw_have_q <= 1'b0;
      wdata_q   <= 8'h0;
      wstrb0_q  <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= rxbc_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= rxbc_pkg::RESP_OKAY;
    end
    else
    begin
      awaddr_q  <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      w_have_q  <= w_have_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Sequencer, checker, decoder and buffer pointers
  logic wr_en;
  logic cfg_hit;
  logic enter_recv;
  logic fail;
  logic bit_err;
  logic take_bit;
  logic pop_ok;
  logic is_t;
  logic is_2t;

  always_comb
  begin
    state_d    = state_q;
    ctrl1_d    = ctrl1_q;
    ctrl3_d    = ctrl3_q;
    ctrl4_d    = ctrl4_q;
    ctrl5_d    = ctrl5_q;
    ctrl6_d    = ctrl6_q;
    div_d      = tick ? 16'h0 : div_q + 16'h1;
    pass_d     = pass_q;
    sleep_d    = sleep_q;
    settle_d   = settle_q;
    armed_d    = armed_q;
    started_d  = started_q;
    centre_d   = centre_q;
    shreg_d    = shreg_q;
    bitcnt_d   = bitcnt_q;
    wr_d       = wr_q;
    rd_d       = rd_q;
    cnt_d      = cnt_q;
    irq_d      = irq_q;
    buf_we     = 1'b0;
    buf_wdata  = 8'h0;
    enter_recv = 1'b0;
    fail       = 1'b0;
    bit_err    = 1'b0;
    take_bit   = 1'b0;
    is_t       = (timer_q >= lmin) && (timer_q < lmax);
    is_2t      = (timer_q >= lmin2) && (timer_q < lmax2);
    // Each interval measured from the previous edge only
    if (edge_seen)
      timer_d = 8'h0;
    else if (tick && timer_q != 8'hff)
      timer_d = timer_q + 8'h1;
    else
      timer_d = timer_q;
    wr_en   = wr_go && wstrb0_q;
    cfg_hit = wr_en && (awaddr_q == rxbc_pkg::ADDR_CTRL1 || awaddr_q == rxbc_pkg::ADDR_CTRL4
              || awaddr_q == rxbc_pkg::ADDR_CTRL5 || awaddr_q == rxbc_pkg::ADDR_CTRL6);
    if (wr_en)
    begin
      if (awaddr_q == rxbc_pkg::ADDR_CTRL1)
        ctrl1_d = wdata_q;
      else if (awaddr_q == rxbc_pkg::ADDR_CTRL3)
        ctrl3_d = wdata_q[1:0];
      else if (awaddr_q == rxbc_pkg::ADDR_CTRL4)
        ctrl4_d = wdata_q[5:0];
      else if (awaddr_q == rxbc_pkg::ADDR_CTRL5)
        ctrl5_d = wdata_q;
      else if (awaddr_q == rxbc_pkg::ADDR_CTRL6)
        ctrl6_d = wdata_q[5:0];
      else if (awaddr_q == rxbc_pkg::ADDR_IRQ_CLR)
        irq_d = 1'b0;
    end

    case (state_q)
      rxbc_pkg::ST_OFF:
        if (opm == rxbc_pkg::OPM_RX_POLL || opm == rxbc_pkg::OPM_RX)
          state_d = rxbc_pkg::ST_PLL;
      rxbc_pkg::ST_SLEEP:
        if (tick)
        begin
          if (sleep_q <= 18'h1)
            state_d = rxbc_pkg::ST_PLL;
          else
            sleep_d = sleep_q - 18'h1;
        end
      rxbc_pkg::ST_PLL:
        if (pll_s)
        begin
          state_d  = rxbc_pkg::ST_SETTLE;
          settle_d = 16'(SETTLE_TICKS);
        end
      rxbc_pkg::ST_SETTLE:
        if (tick)
        begin
          if (settle_q == 16'h0)
          begin
            state_d = rxbc_pkg::ST_CHECK;
            pass_d  = 5'h0;
            armed_d = 1'b0;
          end
          else
            settle_d = settle_q - 16'h1;
        end
      rxbc_pkg::ST_CHECK:
        if (need == 5'h0)
          enter_recv = 1'b1;
        else if (armed_q && timer_q >= lmax)
          fail = 1'b1;
        else if (edge_seen)
        begin
          if (!armed_q)
            armed_d = 1'b1;
          else if (timer_q < lmin)
            fail = 1'b1;
          else if (pass_q + 5'h1 == need)
            enter_recv = 1'b1;
          else
            pass_d = pass_q + 5'h1;
        end
      rxbc_pkg::ST_RECV:
        if (!tmode)
        begin
          if (timer_q >= lmax2)
            bit_err = 1'b1;
          else if (edge_seen)
          begin
            if (is_t)
            begin
              if (started_q && centre_q)
                centre_d = 1'b0;
              else if (started_q)
                take_bit = 1'b1;
            end
            else if (is_2t)
            begin
              // First 2T marks the centre of a start bit unlike the preamble
              if (!started_q || centre_q)
                take_bit = 1'b1;
              else
                bit_err = 1'b1;
            end
            else
              bit_err = 1'b1;
          end
        end
      default:
        state_d = rxbc_pkg::ST_OFF;
    endcase

    if (fail)
    begin
      pass_d  = 5'h0;
      armed_d = 1'b0;
      // Permanent receive mode keeps checking instead of sleeping
      if (opm == rxbc_pkg::OPM_RX_POLL)
      begin
        state_d = rxbc_pkg::ST_SLEEP;
        if (ctrl4_q[rxbc_pkg::CTRL4_XSLP_BIT])
          sleep_d = 18'(ctrl4_q[rxbc_pkg::CTRL4_SLEEP_LSB +: 5])
                    << (rxbc_pkg::SLEEP_UNIT_LOG2 + rxbc_pkg::SLEEP_EXT_LOG2);
        else
          sleep_d = 18'(ctrl4_q[rxbc_pkg::CTRL4_SLEEP_LSB +: 5]) << rxbc_pkg::SLEEP_UNIT_LOG2;
      end
    end
    if (enter_recv)
    begin
      state_d   = rxbc_pkg::ST_RECV;
      ctrl3_d   = 2'h3;
      started_d = 1'b0;
      centre_d  = 1'b0;
      bitcnt_d  = 3'h0;
      if (!tmode && !pmode)
        irq_d = 1'b1;
    end
    if (take_bit)
    begin
      started_d = 1'b1;
      centre_d  = 1'b1;
      shreg_d   = {shreg_q[6:0], demod_s};
      bitcnt_d  = bitcnt_q + 3'h1;
      if (bitcnt_q == 3'h7)
      begin
        buf_we    = 1'b1;
        buf_wdata = {shreg_q[6:0], demod_s};
      end
    end
    if (bit_err)
    begin
      irq_d     = 1'b1;
      state_d   = rxbc_pkg::ST_PLL;
      bitcnt_d  = 3'h0;
      started_d = 1'b0;
      centre_d  = 1'b0;
    end

    pop_ok = pop && cnt_q != 5'h0;
    if (pop_ok)
      rd_d = rd_q + 4'h1;
    if (buf_we)
    begin
      wr_d = wr_q + 4'h1;
      if (cnt_q == 5'(rxbc_pkg::BUF_DEPTH) && !pop_ok)
        rd_d = rd_q + 4'h1;
      else if (!pop_ok)
      begin
        cnt_d = cnt_q + 5'h1;
        if (cnt_q + 5'h1 == fill_thr)
          irq_d = 1'b1;
      end
    end
    else if (pop_ok)
      cnt_d = cnt_q - 5'h1;

    if (cfg_hit && state_q == rxbc_pkg::ST_RECV)
    begin
      buf_we    = 1'b0;
      wr_d      = 4'h0;
      rd_d      = 4'h0;
      cnt_d     = 5'h0;
      bitcnt_d  = 3'h0;
      started_d = 1'b0;
      centre_d  = 1'b0;
      state_d   = rxbc_pkg::ST_SETTLE;
      settle_d  = 16'(SETTLE_TICKS);
    end
    if (ctrl1_d[rxbc_pkg::CTRL1_OPM_LSB +: 2] != rxbc_pkg::OPM_RX_POLL
        && ctrl1_d[rxbc_pkg::CTRL1_OPM_LSB +: 2] != rxbc_pkg::OPM_RX)
      state_d = rxbc_pkg::ST_OFF;

    so_d = demod_s;
    oe_d = (state_d == rxbc_pkg::ST_RECV) && ctrl1_d[rxbc_pkg::CTRL1_TMODE_BIT] && !cs_n_s;
  end

  always_ff @(posedge aclk)
  begin
    if (buf_we)
      mem[wr_q] <= buf_wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q      <= rxbc_pkg::ST_OFF;
      ctrl1_q      <= rxbc_pkg::CTRL1_RST;
      ctrl3_q      <= rxbc_pkg::CTRL3_RST;
      ctrl4_q      <= rxbc_pkg::CTRL4_RST;
      ctrl5_q      <= rxbc_pkg::CTRL5_RST;
      ctrl6_q      <= rxbc_pkg::CTRL6_RST;
      div_q        <= 16'h0;
      timer_q      <= 8'h0;
      pass_q       <= 5'h0;
      sleep_q      <= 18'h0;
      settle_q     <= 16'h0;
      armed_q      <= 1'b0;
      started_q    <= 1'b0;
      centre_q     <= 1'b0;
      shreg_q      <= 8'h0;
      bitcnt_q     <= 3'h0;
      wr_q         <= 4'h0;
      rd_q         <= 4'h0;
      cnt_q        <= 5'h0;
      irq_q        <= 1'b0;
      demod_prev_q <= 1'b0;
      so_q         <= 1'b0;
      oe_q         <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      ctrl1_q      <= ctrl1_d;
      ctrl3_q      <= ctrl3_d;
      ctrl4_q      <= ctrl4_d;
      ctrl5_q      <= ctrl5_d;
      ctrl6_q      <= ctrl6_d;
      div_q        <= div_d;
      timer_q      <= timer_d;
      pass_q       <= pass_d;
      sleep_q      <= sleep_d;
      settle_q     <= settle_d;
      armed_q      <= armed_d;
      started_q    <= started_d;
      centre_q     <= centre_d;
      shreg_q      <= shreg_d;
      bitcnt_q     <= bitcnt_d;
      wr_q         <= wr_d;
      rd_q         <= rd_d;
      cnt_q        <= cnt_d;
      irq_q        <= irq_d;
      demod_prev_q <= demod_s;
      so_q         <= so_d;
      oe_q         <= oe_d;
    end
  end

  assign synth_enable         = state_q != rxbc_pkg::ST_OFF && state_q != rxbc_pkg::ST_SLEEP;
  assign sig_proc_enable      = state_q == rxbc_pkg::ST_SETTLE || state_q == rxbc_pkg::ST_CHECK
                                || state_q == rxbc_pkg::ST_RECV;
  assign rx_active            = state_q == rxbc_pkg::ST_RECV;
  assign serial_out_rx_stream = so_q;
  assign serial_out_oe        = oe_q;
  assign host_supply_enable   = ctrl3_q[rxbc_pkg::CTRL3_SUPPLY_BIT];
  assign host_clock_enable    = ctrl3_q[rxbc_pkg::CTRL3_CLOCK_BIT];
  assign irq                  = irq_q;

endmodule

/* File: tb/rxbc_top_chk_sva.sv */
// Checker of start-up order, host wake and stream pass-through
`timescale 1ns/1ns
module rxbc_top_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Observed ports
  input wire logic pll_locked,
  input wire logic demod_in,
  input wire logic synth_enable,
  input wire logic sig_proc_enable,
  input wire logic rx_active,
  input wire logic serial_out_rx_stream,
  input wire logic serial_out_oe,
  input wire logic host_supply_enable,
  input wire logic host_clock_enable,
  input wire logic irq,
  input wire logic s_axi_bvalid
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_SIG_SYNTH: assert property (sig_proc_enable |-> synth_enable)
    else $error("sig path without synth");
  AST_RX_SIG: assert property (rx_active |-> sig_proc_enable)
    else $error("rx without sig path");
  AST_LOCK_FIRST: assert property ($rose(sig_proc_enable) |-> $past(pll_locked, 2))
    else $error("settle before lock");
  AST_CHECK_FIRST: assert property ($rose(sig_proc_enable) |=> !rx_active [*8])
    else $error("rx too soon");
  AST_WAKE: assert property ($rose(rx_active) |-> ##[0:1] (host_supply_enable && host_clock_enable))
    else $error("host not woken");
  AST_OE_RX: assert property (serial_out_oe |-> rx_active)
    else $error("stream out outside rx");
  AST_STREAM: assert property ($past(aresetn, 3) |-> serial_out_rx_stream == $past(demod_in, 3))
    else $error("stream not raw data");
  AST_RX_EXIT: assert property ($fell(rx_active) |-> (irq || s_axi_bvalid))
    else $error("rx left silently");
  C_RX: cover property ($rose(rx_active));
  C_IRQ: cover property ($rose(irq));
  C_EXIT: cover property ($fell(rx_active));
endmodule
bind rxbc_top rxbc_top_chk u_chk (.*);

/* File: tb/rxbc_far_model.sv */
// Remote transmitter and synthesizer stand-in for the receive front end
`timescale 1ns/1ns
module rxbc_far_model #(
  parameter int HALF = 80
) (
  // Clock
  input  wire logic aclk,
  // Front end
  input  wire logic synth_enable,
  output logic      pll_locked,
  output logic      demod_in
);
  initial
  begin
    pll_locked = 1'b0;
    demod_in = 1'b0;
  end
  // Lock drops one clock after the synth is switched off
  always @(posedge aclk) pll_locked <= synth_enable;
  task automatic half_bit(input logic v);
    demod_in <= v;
    repeat (HALF) @(posedge aclk);
  endtask
  // Zero preburst, then MSB first; line then idles
  task automatic send(input logic [23:0] d, input int n);
    repeat (8)
    begin
      half_bit(1'b1);
      half_bit(1'b0);
    end
    for (int i = n - 1; i >= 0; i--)
    begin
      half_bit(~d[i]);
      half_bit(d[i]);
    end
  endtask
endmodule

/* File: tb/rxbc_top_test.sv */
// Bench for the receive bit-check and byte buffer block
`timescale 1ns/1ns
module rxbc_top_test;
  logic aclk = 1'b0, aresetn = 1'b0, chip_select_n = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic demod_in, pll_locked, synth_enable, sig_proc_enable, rx_active;
  logic serial_out_rx_stream, serial_out_oe, host_supply_enable, host_clock_enable, irq;
  int fails = 0;
  int checks_done = 0;
  // Address, value, response
  logic [41:0] rows [8] = '{{8'h00, 32'h0, 2'h0}, {8'h04, 32'h0, 2'h0}, {8'h08, 32'h0, 2'h0},
    {8'h0c, 32'h4c, 2'h0}, {8'h10, 32'h22, 2'h0}, {8'h14, 32'h0, 2'h0}, {8'h18, 32'h0, 2'h0},
    {8'h20, 32'h0, 2'h3}};
  always #5 aclk = ~aclk;
  rxbc_top #(.CHECK_DIV(4), .SETTLE_TICKS(2)) dut (.*);
  rxbc_far_model fm (.aclk(aclk), .synth_enable(synth_enable), .pll_locked(pll_locked), .demod_in(demod_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks_done++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd(rows[i][41:34]);
      chk(d, rows[i][33:2], "reset read");
      chk({30'h0, r}, {30'h0, rows[i][1:0]}, "resp");
    end
    // Receive mode, fill threshold of one byte; limits stay 12 and 34
    wr(8'h00, 32'h3);
    wait (sig_proc_enable === 1'b1);
    repeat (40) @(posedge aclk);
    fork
      fm.send(24'hb43c5, 20);
      begin
        wait (rx_active === 1'b1);
        repeat (2) @(posedge aclk);
        chk({30'h0, host_supply_enable, host_clock_enable}, 32'h3, "host wake");
        chk({31'h0, irq}, 32'h1, "entry irq");
        wr(8'h1c, 32'h1);
        rd(8'h14);
        chk(d & 32'h101f, 32'h0, "cleared, empty");
        do rd(8'h14);
        while (d[4:0] === 5'h0);
        rd(8'h14);
        chk(d & 32'h101f, 32'h1001, "fill irq");
        wr(8'h1c, 32'h1);
      end
    join
    wait (rx_active === 1'b0);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "error irq");
    rd(8'h14);
    chk({27'h0, d[4:0]}, 32'h2, "partial dropped");
    rd(8'h18);
    chk(d, 32'hb4, "byte 1");
    rd(8'h18);
    chk(d, 32'h3c, "byte 2");
    rd(8'h14);
    chk({27'h0, d[4:0]}, 32'h0, "count down");
    // Transparent mode: raw stream out, no entry interrupt, config write restarts
    wr(8'h1c, 32'h1);
    wr(8'h00, 32'h7);
    chip_select_n <= 1'b0;
    fm.send(24'h0, 0);
    chk({31'h0, rx_active}, 32'h1, "transparent rx");
    chk({31'h0, serial_out_oe}, 32'h1, "stream enable");
    chk({31'h0, serial_out_rx_stream}, {31'h0, demod_in}, "stream level");
    chk({31'h0, irq}, 32'h0, "no entry irq");
    wr(8'h0c, 32'h4c);
    rd(8'h14);
    chk({29'h0, d[10:8]}, 32'h3, "config restart");
    tally_and_finish();
  end
endmodule
